// *** core/sfr_host.sv ***
// Host end: issues read frames and makes the link clock by a divider.
// Assumes one command at a time; reads return bytes as pulses.
`timescale 1ns/10ps
module sfr_host (
	// Clock and reset
	input wire logic clk,
	input wire logic reset,
	// Link
	sfr_link_if.host link,
	// Command
	input wire logic cmd_valid,
	output logic cmd_ready,
	input wire sfr_pkg::sfr_kind_t cmd_kind,
	input wire logic cmd_skip_op,
	input wire logic [23:0] cmd_addr,
	input wire logic [7:0] cmd_mode,
	input wire logic [15:0] cmd_len,
	// Read data
	output logic [7:0] rd_data,
	output logic rd_valid
);
	import sfr_pkg::*;

	// ****************************************
	// Declarations
	// ****************************************
	sfr_host_state_t state; // Frame state
	sfr_kind_t kind; // Command kind of this frame
	logic [2:0] div; // Half period divider
	logic sck; // Link clock register
	logic cs_n; // Select register
	logic rise; // Link clock rises at the next edge
	logic fall; // Link clock falls at the next edge
	logic rise_d; // One cycle after a rise
	logic [TX_W-1:0] tx; // Outgoing shift register
	logic [5:0] cnt; // Link clocks left in the phase
	logic drive; // Host drives the data lines
	logic [15:0] left; // Bytes still to read
	logic [7:0] rx; // Incoming shift register
	logic [7:0] next_rx; // Incoming value after this rise
	logic [2:0] rpos; // Bits taken of current byte
	logic [2:0] next_rpos; // Bits taken after this rise
	logic [1:0] sync1; // First stage of line synchroniser
	logic [1:0] sync2; // Second stage of line synchroniser
	logic wide; // Two-line phase

	// Opcode of a command kind
	function automatic logic [7:0] kind_op(input sfr_kind_t k);
		case (k)
			SFR_K_FAST: kind_op = OP_FAST;
			SFR_K_DUAL_OUT: kind_op = OP_DUAL_OUT;
			SFR_K_DUAL_IO: kind_op = OP_DUAL_IO;
			default: kind_op = OP_READ;
		endcase
	endfunction : kind_op

	// Clocks after the opcode
	function automatic logic [5:0] ad_clks(input sfr_kind_t k);
		case (k)
			SFR_K_NORM: ad_clks = ADDR_CLK_SINGLE;
			SFR_K_DUAL_IO: ad_clks = ADDR_CLK_DUAL + EXTRA_CLK_DUAL;
			SFR_K_CRM: ad_clks = CRM_CLK;
			default: ad_clks = ADDR_CLK_SINGLE + EXTRA_CLK_SINGLE;
		endcase
	endfunction : ad_clks

	assign cmd_ready = (state == SFR_H_IDLE);
	assign rise = (state != SFR_H_IDLE) && (div == HALF_CLKS - 3'h1) && !sck;
	assign fall = (state != SFR_H_IDLE) && (div == HALF_CLKS - 3'h1) && sck;
	assign wide = (state == SFR_H_AD && kind == SFR_K_DUAL_IO) ||
		(state == SFR_H_RD && (kind == SFR_K_DUAL_IO || kind == SFR_K_DUAL_OUT));
	assign next_rx = wide ? {rx[5:0], sync2[1], sync2[0]} : {rx[6:0], sync2[1]};
	assign next_rpos = rpos + (wide ? STEP_DUAL : STEP_SINGLE);

	// ****************************************
	// Pins
	// ****************************************
	assign link.sck = sck;
	assign link.cs_n = cs_n;
	// MSB first; high bit on io1 in two-line phases
	assign link.host_io1 = tx[TX_W-1];
	assign link.host_io0 = wide ? tx[TX_W-2] : tx[TX_W-1];
	assign link.host_io0_oe_n = ~drive;
	assign link.host_io1_oe_n = ~(drive & (wide | kind == SFR_K_CRM));

	// Link clock divider, idle low
	always_ff @(posedge clk or posedge reset) begin
		if (reset) begin
			div <= 3'h0;
			sck <= 1'b0;
		end else if (state == SFR_H_IDLE) begin
			div <= 3'h0;
			sck <= 1'b0;
		end else if (div == HALF_CLKS - 3'h1) begin
			div <= 3'h0;
			sck <= ~sck;
		end else begin
			div <= div + 3'h1;
		end
	end

	// Data line synchronisers and rise delay
	always_ff @(posedge clk or posedge reset) begin
		if (reset) begin
			sync1 <= 2'h0;
			sync2 <= 2'h0;
			rise_d <= 1'b0;
		end else begin
			sync1 <= {link.io1, link.io0};
			sync2 <= sync1;
			rise_d <= rise;
		end
	end

	// Frame sequencer
	always_ff @(posedge clk or posedge reset) begin
		if (reset) begin
			state <= SFR_H_IDLE;
			kind <= SFR_K_NORM;
			cs_n <= 1'b1;
			tx <= '0;
			cnt <= 6'h00;
			drive <= 1'b0;
			left <= 16'h0000;
		end else begin
			case (state)
				SFR_H_IDLE: begin
					if (cmd_valid) begin
						cs_n <= 1'b0;
						kind <= cmd_kind;
						left <= cmd_len;
						drive <= 1'b1;
						if (cmd_kind == SFR_K_CRM) begin
							tx <= CRM_PATTERN;
							state <= SFR_H_AD;
							cnt <= CRM_CLK;
						end else if (cmd_skip_op) begin
							// Continuous mode: address first
							tx <= {cmd_addr, cmd_mode, 8'h00};
							state <= SFR_H_AD;
							cnt <= ad_clks(cmd_kind);
						end else begin
							tx <= {kind_op(cmd_kind), cmd_addr, cmd_mode};
							state <= SFR_H_OP;
							cnt <= OPCODE_CLK;
						end
					end
				end
				SFR_H_OP: begin
					if (rise_d) begin
						tx <= {tx[TX_W-2:0], 1'b0};
						cnt <= (cnt == 6'h01) ? ad_clks(kind) : cnt - 6'h01;
						if (cnt == 6'h01) begin
							state <= SFR_H_AD;
						end
					end
				end
				SFR_H_AD: begin
					if (rise_d) begin
						tx <= wide ? {tx[TX_W-3:0], 2'b00} : {tx[TX_W-2:0], 1'b0};
						cnt <= cnt - 6'h01;
						if (cnt == 6'h01) begin
							// Let go during the high half of the last clock
							drive <= 1'b0;
							state <= (kind == SFR_K_CRM || left == 16'h0000) ? SFR_H_FIN : SFR_H_RD;
						end
					end
				end
				SFR_H_RD: begin
					if (rise && next_rpos == 3'h0) begin
						left <= left - 16'h0001;
						if (left == 16'h0001) begin
							state <= SFR_H_FIN;
						end
					end
				end
				SFR_H_FIN: begin
					// Deselect with the clock low
					if (fall) begin
						cs_n <= 1'b1;
						state <= SFR_H_IDLE;
					end
				end
				default: begin
					state <= SFR_H_IDLE;
				end
			endcase
		end
	end

	// Read data assembly
	always_ff @(posedge clk or posedge reset) begin
		if (reset) begin
			rx <= 8'h00;
			rpos <= 3'h0;
			rd_data <= 8'h00;
			rd_valid <= 1'b0;
		end else begin
			rd_valid <= 1'b0;
			if (state == SFR_H_IDLE) begin
				rpos <= 3'h0;
			end else if (rise && state == SFR_H_RD) begin
				rx <= next_rx;
				rpos <= next_rpos;
				if (next_rpos == 3'h0) begin
					rd_data <= next_rx;
					rd_valid <= 1'b1;
				end
			end
		end
	end

endmodule : sfr_host

// *** core/sfr_pkg.sv ***
// Constants, types and encodings of the serial flash read engine.
// Assumes a mode 0 serial link: data taken on rising; the device drives on falling, the host one clock after rising.
package sfr_pkg;

	// ****************************************
	// Opcodes and widths
	// ****************************************
	localparam logic [7:0] OP_READ = 8'h03;
	localparam logic [7:0] OP_FAST = 8'h0B;
	localparam logic [7:0] OP_DUAL_OUT = 8'h3B;
	localparam logic [7:0] OP_DUAL_IO = 8'hBB;
	localparam int ADDR_W = 20;
	localparam int TX_W = 40;
	localparam logic [TX_W-1:0] CRM_PATTERN = 40'hFFFFFFFFFF;

	// ****************************************
	// Phase lengths in link clocks, and bits per clock
	// ****************************************
	localparam logic [5:0] OPCODE_CLK = 6'h08;
	localparam logic [5:0] ADDR_CLK_SINGLE = 6'h18;
	localparam logic [5:0] ADDR_CLK_DUAL = 6'h0C;
	localparam logic [5:0] EXTRA_CLK_SINGLE = 6'h08;
	localparam logic [5:0] EXTRA_CLK_DUAL = 6'h04;
	localparam logic [5:0] CRM_CLK = 6'h10;
	localparam logic [2:0] STEP_SINGLE = 3'h1;
	localparam logic [2:0] STEP_DUAL = 3'h2;

	// ****************************************
	// Continuous read mode bits
	// ****************************************
	localparam int CTRL_HI = 5;
	localparam int CTRL_LO = 4;
	localparam logic [1:0] CTRL_CONT = 2'h2;
	localparam logic [7:0] CRM_EXIT_MASK = 8'h10;
	localparam logic [7:0] CRM_RESET_VAL = 8'h10;

	// ****************************************
	// Host link timing
	// ****************************************
	localparam int CLK_NS = 10;
	localparam int SCK_HALF_NS = 40;
	localparam logic [2:0] HALF_CLKS = 3'((SCK_HALF_NS + CLK_NS - 1) / CLK_NS);

	// ****************************************
	// Types
	// ****************************************
	typedef enum logic [1:0] {
		SFR_RD_NORM = 2'h0,
		SFR_RD_FAST = 2'h1,
		SFR_RD_DUAL_OUT = 2'h2,
		SFR_RD_DUAL_IO = 2'h3
	} sfr_read_t;

	typedef enum logic [2:0] {
		SFR_K_NORM = 3'h0,
		SFR_K_FAST = 3'h1,
		SFR_K_DUAL_OUT = 3'h2,
		SFR_K_DUAL_IO = 3'h3,
		SFR_K_CRM = 3'h4
	} sfr_kind_t;

	typedef enum logic [2:0] {
		SFR_D_CMD = 3'h0,
		SFR_D_ADDR = 3'h1,
		SFR_D_EXTRA = 3'h3,
		SFR_D_DATA = 3'h2,
		SFR_D_IGNORE = 3'h6
	} sfr_dev_state_t;

	typedef enum logic [2:0] {
		SFR_H_IDLE = 3'h0,
		SFR_H_OP = 3'h1,
		SFR_H_AD = 3'h3,
		SFR_H_RD = 3'h2,
		SFR_H_FIN = 3'h6
	} sfr_host_state_t;

endpackage : sfr_pkg

// *** core/sfr_link_if.sv ***
// Serial link between the flash read engine and its host.
// Assumes a pull-up on both data lines when nobody drives them.
`timescale 1ns/10ps
interface sfr_link_if;

	// Clock and select, made by the host
	logic sck;
	logic cs_n;
	// Host drive of the data lines
	logic host_io0;
	logic host_io0_oe_n;
	logic host_io1;
	logic host_io1_oe_n;
	// Device drive of the data lines
	logic dev_io0;
	logic dev_io0_oe_n;
	logic dev_io1;
	logic dev_io1_oe_n;
	// Resolved line levels
	logic io0;
	logic io1;

	// Device drive wins, else host, else pull-up
	assign io0 = !dev_io0_oe_n ? dev_io0 : (!host_io0_oe_n ? host_io0 : 1'b1);
	assign io1 = !dev_io1_oe_n ? dev_io1 : (!host_io1_oe_n ? host_io1 : 1'b1);

	modport device (
		input sck, cs_n, io0, io1,
		output dev_io0, dev_io0_oe_n, dev_io1, dev_io1_oe_n
	);

	modport host (
		output sck, cs_n, host_io0, host_io0_oe_n, host_io1, host_io1_oe_n,
		input io0, io1
	);

endinterface : sfr_link_if

// *** core/sfr_device.sv ***
// Flash side of the read engine, clocked by the link clock.
// Assumes the array answers mem_rdata combinationally from mem_addr.
`timescale 1ns/10ps
module sfr_device (
	// Link
	sfr_link_if.device link,
	// Reset, asynchronous
	input wire logic reset,
	// Array read port
	output logic [sfr_pkg::ADDR_W-1:0] mem_addr,
	input wire logic [7:0] mem_rdata,
	// Status
	output logic cont_mode
);
	import sfr_pkg::*;

	// ****************************************
	// Declarations
	// ****************************************
	// Frame reset: reset or deselect
	logic frame_rst;
	// Frame state
	sfr_dev_state_t state;
	// Read variant of this frame
	sfr_read_t cur;
	// Clock count within a phase
	logic [4:0] cnt;
	// Input shift register
	logic [23:0] sh;
	logic [23:0] next_sh;
	// Captured mode byte
	logic [7:0] cont_read_mode_bits;
	// Control pair of the mode byte
	logic [1:0] cont_read_ctrl_pair;
	// Io0 held high all through the frame
	logic rst_ones;
	// Bits already sent of current byte
	logic [2:0] bpos;
	// Output shift register
	logic [7:0] out_sh;
	// Output drive in data phase
	logic drive;
	// Two-line input phase
	logic wide_in;
	// Two-line output variant
	logic wide_out;
	// Bits per data clock
	logic [2:0] step;
	// Clocks in the current phase
	logic [5:0] phase_len;
	// Last clock of the phase
	logic last;
	// Mode reset seen on this clock
	logic rst_hit;

	// ****************************************
	// Decoding
	// ****************************************
	// Known read opcodes
	function automatic logic op_known(input logic [7:0] op);
		op_known = (op == OP_READ) || (op == OP_FAST) ||
			(op == OP_DUAL_OUT) || (op == OP_DUAL_IO);
	endfunction : op_known

	// Read variant of an opcode
	function automatic sfr_read_t op_mode(input logic [7:0] op);
		case (op)
			OP_FAST: op_mode = SFR_RD_FAST;
			OP_DUAL_OUT: op_mode = SFR_RD_DUAL_OUT;
			OP_DUAL_IO: op_mode = SFR_RD_DUAL_IO;
			default: op_mode = SFR_RD_NORM;
		endcase
	endfunction : op_mode

	// Deselect acts at once on all frame state
	assign frame_rst = reset | link.cs_n;
	assign cont_read_ctrl_pair = cont_read_mode_bits[CTRL_HI:CTRL_LO];
	assign cont_mode = (cont_read_ctrl_pair == CTRL_CONT);
	assign wide_out = (cur == SFR_RD_DUAL_OUT) || (cur == SFR_RD_DUAL_IO);
	assign step = wide_out ? STEP_DUAL : STEP_SINGLE;

	// Phase width and length
	always_comb begin
		wide_in = 1'b0;
		phase_len = OPCODE_CLK;
		case (state)
			SFR_D_CMD: begin
				// Continuous mode frame begins with address
				wide_in = cont_mode;
			end
			SFR_D_ADDR: begin
				wide_in = (cur == SFR_RD_DUAL_IO);
				phase_len = wide_in ? ADDR_CLK_DUAL : ADDR_CLK_SINGLE;
			end
			SFR_D_EXTRA: begin
				wide_in = (cur == SFR_RD_DUAL_IO);
				phase_len = wide_in ? EXTRA_CLK_DUAL : EXTRA_CLK_SINGLE;
			end
			default: begin
				phase_len = OPCODE_CLK;
			end
		endcase
		last = ({1'b0, cnt} == phase_len - 6'h01);
		// Opcode and address arrive MSB first
		next_sh = wide_in ? {sh[21:0], link.io1, link.io0} : {sh[22:0], link.io0};
		// Reset pattern: ones on io0 for the whole frame
		rst_hit = rst_ones && link.io0;
	end

	// ****************************************
	// Input side, rising edge
	// ****************************************
	// Frame sequencer
	always_ff @(posedge link.sck or posedge frame_rst) begin
		if (frame_rst) begin
			state <= SFR_D_CMD;
			cur <= SFR_RD_NORM;
			cnt <= 5'h00;
			sh <= 24'h000000;
		end else begin
			sh <= next_sh;
			cnt <= last ? 5'h00 : cnt + 5'h01;
			case (state)
				SFR_D_CMD: begin
					if (cont_mode) begin
						// First clock already carries address bits
						state <= SFR_D_ADDR;
						cur <= SFR_RD_DUAL_IO;
						cnt <= 5'h01;
					end else if (last) begin
						if (op_known(next_sh[7:0])) begin
							state <= SFR_D_ADDR;
							cur <= op_mode(next_sh[7:0]);
						end else begin
							// Stay deaf until reselect
							state <= SFR_D_IGNORE;
						end
					end
				end
				SFR_D_ADDR: begin
					if (last) begin
						// Normal read has no dummy byte
						state <= (cur == SFR_RD_NORM) ? SFR_D_DATA : SFR_D_EXTRA;
					end
				end
				SFR_D_EXTRA: begin
					if (last) begin
						// Dummy value is not looked at; in dual IO the mode byte is checked for the reset pattern
						if (cur == SFR_RD_DUAL_IO && rst_hit) begin
							state <= SFR_D_IGNORE;
						end else begin
							state <= SFR_D_DATA;
						end
					end
				end
				SFR_D_DATA: begin
					// Streams until deselect
					state <= SFR_D_DATA;
				end
				SFR_D_IGNORE: begin
					state <= SFR_D_IGNORE;
				end
				default: begin
					state <= SFR_D_IGNORE;
				end
			endcase
		end
	end

	// Track io0 staying high through the frame
	always_ff @(posedge link.sck or posedge frame_rst) begin
		if (frame_rst) begin
			rst_ones <= 1'b1;
		end else if (!link.io0) begin
			rst_ones <= 1'b0;
		end
	end

	// Mode byte capture, kept across frames
	always_ff @(posedge link.sck or posedge reset) begin
		if (reset) begin
			cont_read_mode_bits <= CRM_RESET_VAL;
		end else if (!link.cs_n && state == SFR_D_EXTRA && last && cur == SFR_RD_DUAL_IO) begin
			if (rst_hit) begin
				// Forcing bit four leaves continuous mode
				cont_read_mode_bits <= next_sh[7:0] | CRM_EXIT_MASK;
			end else begin
				// Whole byte kept; only the pair is ever used
				cont_read_mode_bits <= next_sh[7:0];
			end
		end
	end

	// Array address counter
	always_ff @(posedge link.sck or posedge reset) begin
		if (reset) begin
			mem_addr <= '0;
		end else if (!link.cs_n && state == SFR_D_ADDR && last) begin
			// Upper address bits are dropped
			mem_addr <= next_sh[ADDR_W-1:0];
		end else if (!link.cs_n && state == SFR_D_DATA && bpos == step) begin
			// Next byte once the current one is loaded; wraps at array end
			mem_addr <= mem_addr + 20'h00001;
		end
	end

	// ****************************************
	// Output side, falling edge
	// ****************************************
	// Byte loader and shifter
	always_ff @(negedge link.sck or posedge frame_rst) begin
		if (frame_rst) begin
			bpos <= 3'h0;
			out_sh <= 8'h00;
			drive <= 1'b0;
		end else if (state == SFR_D_DATA) begin
			drive <= 1'b1;
			if (bpos == 3'h0) begin
				// New byte, no gap even across the wrap
				out_sh <= mem_rdata;
			end else if (wide_out) begin
				out_sh <= {out_sh[5:0], 2'b00};
			end else begin
				out_sh <= {out_sh[6:0], 1'b0};
			end
			bpos <= bpos + step;
		end
	end

	// ****************************************
	// Pins
	// ****************************************
	// Bit 7 on io1, bit 6 on io0 in dual reads
	assign link.dev_io1 = out_sh[7];
	assign link.dev_io0 = wide_out ? out_sh[6] : 1'b0;
	// Undriven outside data phase and when deselected
	assign link.dev_io1_oe_n = link.cs_n | ~drive;
	assign link.dev_io0_oe_n = link.cs_n | ~drive | ~wide_out;

endmodule : sfr_device

// *** dv/sfr_link_assertions.sv ***
// Link checks for the serial flash read engine, fed by interface signals.
// Assumes both ends joined by one sfr_link_if; clk is the host clock.
`timescale 1ns/10ps
module sfr_link_assertions (
	// Clocks and reset
	input wire logic clk,
	input wire logic reset,
	// Link lines
	input wire logic sck,
	input wire logic cs_n,
	input wire logic host_io0_oe_n,
	input wire logic host_io1_oe_n,
	input wire logic dev_io0_oe_n,
	input wire logic dev_io1_oe_n,
	input wire logic io0
);
	import sfr_pkg::*;

	// ****************************************
	// Frame tracking
	// ****************************************
	logic [11:0] cnt; // Link rises seen in this frame
	logic [7:0] op; // First byte seen on io0

	// Count rises, cleared while deselected
	always_ff @(posedge sck or posedge cs_n or posedge reset) begin
		if (reset || cs_n) begin
			cnt <= 12'h000;
		end else if (cnt != 12'hFFF) begin
			cnt <= cnt + 12'h001;
		end
	end

	// Collect the opcode bits
	always_ff @(posedge sck or posedge reset) begin
		if (reset) begin
			op <= 8'h00;
		end else if (cnt < 12'h008) begin
			op <= {op[6:0], io0};
		end
	end

	// ****************************************
	// Assertions
	// ****************************************
	sel_release_a: assert property (@(posedge clk) disable iff (reset)
		cs_n |-> dev_io0_oe_n && dev_io1_oe_n) else $error("Device drives while deselected");
	hdr_drive_a: assert property (@(posedge sck) disable iff (reset)
		cnt < 12'h008 |-> !host_io0_oe_n && dev_io0_oe_n && dev_io1_oe_n)
		else $error("Bad drive in first byte");
	norm_edge_a: assert property (@(posedge sck) disable iff (reset)
		op == OP_READ && cnt >= 12'h008 |-> dev_io1_oe_n == (cnt < 12'h020) && dev_io0_oe_n)
		else $error("Normal read output edge wrong");
	fast_edge_a: assert property (@(posedge sck) disable iff (reset)
		op == OP_FAST && cnt >= 12'h008 |-> dev_io1_oe_n == (cnt < 12'h028) && dev_io0_oe_n)
		else $error("Fast read output edge wrong");
	dual_edge_a: assert property (@(posedge sck) disable iff (reset)
		op == OP_DUAL_OUT && cnt >= 12'h008 |-> dev_io0_oe_n == (cnt < 12'h028)
		&& dev_io1_oe_n == (cnt < 12'h028)) else $error("Dual output edge wrong");
	dio_edge_a: assert property (@(posedge sck) disable iff (reset)
		op == OP_DUAL_IO && cnt >= 12'h008 |-> dev_io0_oe_n == (cnt < 12'h018)
		&& dev_io1_oe_n == (cnt < 12'h018)) else $error("Dual IO output edge wrong");
	unk_quiet_a: assert property (@(posedge sck) disable iff (reset)
		op == 8'hFF && cnt >= 12'h008 |-> dev_io0_oe_n && dev_io1_oe_n)
		else $error("Device answers an all ones frame");
	host_float_a: assert property (@(posedge sck) disable iff (reset)
		op == OP_DUAL_IO && cnt >= 12'h018 |-> host_io0_oe_n && host_io1_oe_n)
		else $error("Host still drives in dual data phase");
	host_rel_a: assert property (@(posedge sck) disable iff (reset)
		op == OP_READ && cnt >= 12'h020 |-> host_io0_oe_n) else $error("Host drives in data");

	// Main scenarios reached
	cover property (@(posedge sck) op == OP_DUAL_IO && cnt == 12'h018);
	cover property (@(posedge sck) op == OP_FAST && cnt == 12'h028);
	cover property (@(posedge sck) op == 8'hFF && cnt == 12'h00A);
endmodule : sfr_link_assertions

// *** dv/tb.sv ***
// Testbench joining host and device ends of the read engine.
// Assumes the array is modelled here and answers at once.
`timescale 1ns/10ps
module tb;
	import sfr_pkg::*;

	// ****************************************
	// Signals and instances
	// ****************************************
	logic clk; // 100 MHz host clock
	logic reset; // Shared async reset
	logic cmd_valid;
	logic cmd_ready;
	sfr_kind_t cmd_kind;
	logic cmd_skip_op;
	logic [23:0] cmd_addr;
	logic [7:0] cmd_mode;
	logic [15:0] cmd_len;
	logic [7:0] rd_data;
	logic rd_valid;
	logic [ADDR_W-1:0] mem_addr;
	logic [7:0] mem_rdata;
	logic cont_mode;
	int n_errors = 0;
	int n_checks = 0;

	// Array contents as a pattern of the address
	function automatic logic [7:0] mem_byte(input logic [ADDR_W-1:0] a);
		return a[7:0] ^ {a[19:16], a[11:8]};
	endfunction : mem_byte

	assign mem_rdata = mem_byte(mem_addr);
	sfr_link_if link();
	sfr_host u_sfr_host (.clk(clk), .reset(reset), .link(link), .cmd_valid(cmd_valid),
		.cmd_ready(cmd_ready), .cmd_kind(cmd_kind), .cmd_skip_op(cmd_skip_op),
		.cmd_addr(cmd_addr), .cmd_mode(cmd_mode), .cmd_len(cmd_len), .rd_data(rd_data),
		.rd_valid(rd_valid));
	sfr_device u_sfr_device (.link(link), .reset(reset), .mem_addr(mem_addr),
		.mem_rdata(mem_rdata), .cont_mode(cont_mode));
	sfr_link_assertions u_chk (.clk(clk), .reset(reset), .sck(link.sck), .cs_n(link.cs_n),
		.host_io0_oe_n(link.host_io0_oe_n), .host_io1_oe_n(link.host_io1_oe_n),
		.dev_io0_oe_n(link.dev_io0_oe_n), .dev_io1_oe_n(link.dev_io1_oe_n), .io0(link.io0));

	// ****************************************
	// Shared tasks
	// ****************************************
	// Compare and count
	task automatic check(input logic [7:0] got, input logic [7:0] exp);
		n_checks++;
		if (got !== exp) begin
			n_errors++;
			$display("[FAIL] %0t ns got %h exp %h", $time, got, exp);
		end
	endtask : check

	// Wait for the host to be idle, bounded
	task automatic wait_ready();
		int w;
		w = 0;
		while (cmd_ready !== 1'b1 && w < 4000) begin
			@(posedge clk);
			#1 w++;
		end
	endtask : wait_ready

	// Issue one frame and compare every returned byte
	task automatic do_read(input sfr_kind_t k, input logic sk, input logic [23:0] a,
		input logic [7:0] m, input logic [15:0] n);
		int w;
		logic [ADDR_W-1:0] p;
		p = a[ADDR_W-1:0];
		wait_ready();
		cmd_kind = k;
		cmd_skip_op = sk;
		cmd_addr = a;
		cmd_mode = m;
		cmd_len = n;
		cmd_valid = 1'b1;
		@(posedge clk);
		#1 cmd_valid = 1'b0;
		for (int i = 0; i < n; i++) begin
			w = 0;
			while (rd_valid !== 1'b1 && w < 2000) begin
				@(posedge clk);
				#1 w++;
			end
			check({7'h00, rd_valid}, 8'h01);
			check(rd_data, mem_byte(p));
			p = p + ADDR_W'(1);
			@(posedge clk);
			#1;
		end
		wait_ready();
	endtask : do_read

	// ****************************************
	// Scenarios
	// ****************************************
	// Idle state after reset
	task automatic t_reset();
		check({7'h00, cont_mode}, 8'h00);
		check({5'h00, link.cs_n, link.dev_io0_oe_n, link.dev_io1_oe_n}, 8'h07);
		$display("t_reset done");
	endtask : t_reset

	// Single line reads, upper address nibble ignored, wrap at the top
	task automatic t_single();
		do_read(SFR_K_NORM, 1'b0, 24'h012345, 8'h00, 16'h0003);
		do_read(SFR_K_NORM, 1'b0, 24'hF12345, 8'h00, 16'h0002);
		do_read(SFR_K_FAST, 1'b0, 24'h0FFFFE, 8'h5A, 16'h0004);
		$display("t_single done");
	endtask : t_single

	// Dual output read across the wrap
	task automatic t_dual();
		do_read(SFR_K_DUAL_OUT, 1'b0, 24'h0FFFFF, 8'hC3, 16'h0003);
		$display("t_dual done");
	endtask : t_dual

	// Dual IO read entering, keeping and leaving continuous mode
	task automatic t_dio();
		do_read(SFR_K_DUAL_IO, 1'b0, 24'h00ABCD, 8'hA5, 16'h0002);
		check({7'h00, cont_mode}, 8'h01);
		do_read(SFR_K_DUAL_IO, 1'b1, 24'h0FFFFE, 8'h2F, 16'h0003);
		check({7'h00, cont_mode}, 8'h01);
		do_read(SFR_K_DUAL_IO, 1'b1, 24'h0FFFF0, 8'h3C, 16'h0001);
		check({7'h00, cont_mode}, 8'h00);
		do_read(SFR_K_NORM, 1'b0, 24'h000010, 8'h00, 16'h0001);
		$display("t_dio done");
	endtask : t_dio

	// Mode reset, then the same pattern as an unknown opcode
	task automatic t_crm();
		do_read(SFR_K_DUAL_IO, 1'b0, 24'h000100, 8'hE0, 16'h0001);
		check({7'h00, cont_mode}, 8'h01);
		do_read(SFR_K_CRM, 1'b0, 24'h000000, 8'hFF, 16'h0000);
		check({7'h00, cont_mode}, 8'h00);
		do_read(SFR_K_CRM, 1'b0, 24'h000000, 8'hFF, 16'h0000);
		check({7'h00, cont_mode}, 8'h00);
		do_read(SFR_K_NORM, 1'b0, 24'h0ABCDE, 8'h00, 16'h0002);
		$display("t_crm done");
	endtask : t_crm

	// Reset in mid run clears continuous mode
	task automatic t_rst();
		do_read(SFR_K_DUAL_IO, 1'b0, 24'h000200, 8'h20, 16'h0001);
		reset = 1'b1;
		repeat (2) @(posedge clk);
		#1 reset = 1'b0;
		check({7'h00, cont_mode}, 8'h00);
		do_read(SFR_K_NORM, 1'b0, 24'h000300, 8'h00, 16'h0001);
		$display("t_rst done");
	endtask : t_rst

	// Verdict and end of run
	task automatic complete_run();
		$display("checks %0d errors %0d", n_checks, n_errors);
		if (n_errors == 0 && n_checks > 0) begin
			$display("*** PASS ***");
		end else begin
			$display("*** FAIL ***");
		end
		$finish;
	endtask : complete_run

	// Clock
	initial begin
		clk = 1'b0;
		forever #5 clk = ~clk;
	end

	// Main sequence
	initial begin
		reset = 1'b1;
		cmd_valid = 1'b0;
		cmd_kind = SFR_K_NORM;
		cmd_skip_op = 1'b0;
		cmd_addr = 24'h000000;
		cmd_mode = 8'h00;
		cmd_len = 16'h0000;
		repeat (20) @(posedge clk);
		#1 reset = 1'b0;
		t_reset();
		t_single();
		t_dual();
		t_dio();
		t_crm();
		t_rst();
		complete_run();
	end

	// Watchdog against a hung frame
	initial begin
		repeat (50000) @(posedge clk);
		n_errors++;
		complete_run();
	end
endmodule : tb
